// ---- iop_core_model.sv ----
// Purpose: Core-side partner that starts service of granted interrupt sources.
// Assumes: Grants are one-hot, so the lowest set bit names the served source.
// Notes: A lag of zero models a core that never serves, so latches can be seen to hold.
`timescale 1ns/1ps
module iop_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [4:0] irqGrant,
    input wire logic [3:0] ackLag,
    output logic ackValid,
    output logic [2:0] ackSrc
);
    logic [3:0] held;
    logic [2:0] lowest;

    assign lowest = irqGrant[0] ? 3'h0 : irqGrant[1] ? 3'h1 : irqGrant[2] ? 3'h2 :
        irqGrant[3] ? 3'h3 : 3'h4;

    // Service begins only after the grant has stood for the whole lag.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            held <= 4'h0;
            ackValid <= 1'b0;
            ackSrc <= 3'h0;
        end else if (irqGrant == 5'h00 || ackLag == 4'h0 || ackValid) begin
            held <= 4'h0;
            ackValid <= 1'b0;
        end else if (held + 4'h1 >= ackLag) begin
            ackValid <= 1'b1;
            ackSrc <= lowest;
            held <= 4'h0;
        end else begin
            held <= held + 4'h1;
        end
    end
endmodule

// ---- iop_ctrl.sv ----
// Purpose: Interrupt option register, source routing and wait/stop sequencing.
// Assumes: Core reports its mode and acknowledges each serviced source.
// Notes: Pins pass two flip-flops before any logic reads them.
//
// How it works
// - Option register is write-only, reads zero.
// - All option bits clear on reset.
// - Bit 7 and bits 3-0 ignored.
// - Level select: source 1 level else edge.
// - Polarity bit picks source 2 edge.
// - One rising, zero falling; source 1 falling.
// - Global enable off blocks all but NMI.
// - NMI serviced but no wake when disabled.
// - Enable off: only reset leaves low power.
// - Each peripheral event but SPI done gated by its mask.
// - Conversion done needs converter enable bit.
// - Wait halts fetch, keeps oscillator running.
// - Wait wake resumes with no delay.
// - Stop halts oscillator until external interrupt.
// - Stop wake waits for oscillator stabilisation.
// - Pin or watchdog reset runs normal reset.
// - From main routine, waking interrupt serviced first.
// - From NMI handler, resume next, stay NMI.
// - Maskable wake in handler resumes handler.
// - NMI wake in handler runs NMI first.
// - Active watchdog turns stop into wait.
// - Pending enabled request skips wait or stop.
// - Waking leaves oscillator selection unchanged.
// - Fixed priority: NMI, then source 1..4.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module iop_ctrl
    import iop_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic waitExec,
    input wire logic stopExec,
    input wire logic [1:0] coreMode,
    input wire logic wdActive,
    input wire logic ackValid,
    input wire logic [2:0] ackSrc,
    output logic [4:0] irqGrant,
    output logic fetchHalt,
    output logic oscEnable,
    output logic oscSelect,
    output logic wakeResume,
    output logic instrSkip,
    input wire logic spiDone,
    input wire logic timerZero,
    input wire logic osc32Event,
    input wire logic convDone,
    input wire logic nmiPin_b,
    input wire logic src1Pin_b,
    input wire logic src2Pin
);
    // Lowest-numbered request wins; bit 0 is the highest rank.
    function automatic logic [4:0] iop_first(input logic [4:0] req);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 4; i >= 0; i--) begin
            if (req[i]) begin
                res = 5'h00;
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction

    logic [7:0] optReg;
    logic [7:0] maskReg;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic [2:0] pinPrev;
    logic src1Prev;
    logic nmiLatch;
    logic s1Latch;
    logic s2Latch;
    logic [1:0] entryMode;
    logic [11:0] stabCnt;
    iop_pwr_t pwr;
    iop_pwr_t next_pwr;

    wire levelSel = optReg[IOP_LEVEL_BIT];
    wire edgePol = optReg[IOP_POL_BIT];
    wire globalIrqEnable = optReg[IOP_ENABLE_BIT];

    // Register bus: write path pairs address and data in either order.
    wire doWrite = awHeld & wHeld & ~bvalid;
    wire wrOpt = awAddrQ == IOP_OPT_OFS;
    wire wrMask = awAddrQ == IOP_MASK_OFS;
    wire wrStat = awAddrQ == IOP_STAT_OFS;
    wire wrMapped = wrOpt | wrMask | wrStat;
    assign awready = ~awHeld & ~bvalid;
    assign wready = ~wHeld & ~bvalid;
    assign arready = ~rvalid;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h0;
            wStrbQ <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awAddrQ <= awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp <= IOP_RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrMapped ? IOP_RESP_OKAY : IOP_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            optReg <= IOP_OPT_RESET;
            maskReg <= IOP_MASK_RESET;
        end else if (doWrite && wStrbQ[0]) begin
            if (wrOpt) begin
                optReg <= wDataQ[7:0] & IOP_OPT_USED;
            end else if (wrMask) begin
                maskReg <= wDataQ[7:0] & IOP_MASK_USED;
            end
        end
    end

    assign oscSelect = maskReg[IOP_MSK_OSCSEL];

    // Read path; the option register keeps no readable copy.
    wire [4:0] pendVec;
    wire [31:0] statWord = {21'h0, entryMode, pendVec, pwr};
    wire rdOpt = araddr == IOP_OPT_OFS;
    wire rdMask = araddr == IOP_MASK_OFS;
    wire rdStat = araddr == IOP_STAT_OFS;
    wire [31:0] rdMux = rdMask ? {24'h0, maskReg} : rdStat ? statWord : 32'h0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= IOP_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdMux;
            rresp <= (rdOpt | rdMask | rdStat) ? IOP_RESP_OKAY : IOP_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Pin synchronisers; order is {src2, src1, nmi}.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta <= 3'h7;
            pinSync <= 3'h7;
            pinPrev <= 3'h7;
        end else begin
            pinMeta <= {src2Pin, src1Pin_b, nmiPin_b};
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    wire nmiEdge = pinPrev[0] & ~pinSync[0];
    wire src1Line = ~pinSync[1] | spiDone;
    // falling pin gives source 1 edge
    wire src1Edge = src1Line & ~src1Prev;
    wire src2Edge = edgePol ? (pinSync[2] & ~pinPrev[2]) : (~pinSync[2] & pinPrev[2]);
    wire ackNmi = ackValid && ackSrc == 3'h0;
    wire ackS1 = ackValid && ackSrc == 3'h1;
    wire ackS2 = ackValid && ackSrc == 3'h2;

    // Edge latches: a new edge wins over the acknowledge in the same cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src1Prev <= 1'b0;
            nmiLatch <= 1'b0;
            s1Latch <= 1'b0;
            s2Latch <= 1'b0;
        end else begin
            src1Prev <= src1Line;
            nmiLatch <= nmiEdge | (nmiLatch & ~ackNmi);
            s1Latch <= (src1Edge & ~levelSel) | (s1Latch & ~ackS1 & ~levelSel);
            s2Latch <= src2Edge | (s2Latch & ~ackS2);
        end
    end

    wire s1Req = levelSel ? src1Line : s1Latch;
    // timer and oscillator onto source 3
    wire s3Req = (timerZero & maskReg[IOP_MSK_TIMER]) | (osc32Event & maskReg[IOP_MSK_OSC32]);
    wire s4Req = convDone & maskReg[IOP_MSK_CONV];
    wire [3:0] rawReq = {s4Req, s3Req, s2Latch, s1Req};
    wire [3:0] maskedReq = globalIrqEnable ? rawReq : 4'h0;
    assign pendVec = {maskedReq, nmiLatch};
    wire enabledPending = |pendVec;

    // Arbitration runs only while executing; the core mode decides who may
    // preempt, which also gives the right order after a wake-up.
    // NMI serviced regardless of enable
    wire nmiOk = nmiLatch && coreMode != IOP_MODE_NMI;
    wire maskOk = coreMode == IOP_MODE_NORMAL;
    wire [4:0] grantReq = {maskOk ? maskedReq : 4'h0, nmiOk};
    assign irqGrant = (pwr == PS_RUN) ? iop_first(grantReq) : 5'h00;

    // Wake conditions; with enable low nothing but reset ends low power.
    // no NMI wake when disabled
    wire waitWake = globalIrqEnable & (nmiLatch | |rawReq);
    wire stopWake = globalIrqEnable & (nmiLatch | s1Req | s2Latch);
    wire lpEnter = waitExec | stopExec;
    wire goStop = stopExec & ~wdActive;

    always_comb begin
        next_pwr = pwr;
        case (pwr)
            PS_RUN: begin
                if (lpEnter && !enabledPending) begin
                    next_pwr = goStop ? PS_STOP : PS_WAIT;
                end
            end
            PS_WAIT: begin
                if (waitWake) begin
                    next_pwr = PS_RUN;
                end
            end
            PS_STOP: begin
                if (stopWake) begin
                    next_pwr = PS_STAB;
                end
            end
            PS_STAB: begin
                if (stabCnt == 12'h001) begin
                    next_pwr = PS_RUN;
                end
            end
            default: begin
                next_pwr = PS_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr <= PS_RUN;
        end else begin
            pwr <= next_pwr;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stabCnt <= 12'h000;
        end else if (pwr == PS_STOP && stopWake) begin
            stabCnt <= IOP_STAB_LOAD;
        end else if (pwr == PS_STAB) begin
            stabCnt <= stabCnt - 12'h001;
        end
    end

    // The mode at entry is kept so software can see how the core slept.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            entryMode <= IOP_MODE_NORMAL;
            instrSkip <= 1'b0;
            wakeResume <= 1'b0;
        end else begin
            if (pwr == PS_RUN && lpEnter && !enabledPending) begin
                entryMode <= coreMode;
            end
            instrSkip <= pwr == PS_RUN && lpEnter && enabledPending;
            wakeResume <= (pwr != PS_RUN) && next_pwr == PS_RUN;
        end
    end

    assign fetchHalt = pwr != PS_RUN;
    assign oscEnable = pwr != PS_STOP;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence stopWakeS;
        pwr == PS_STOP && stopWake;
    endsequence

    sequence stabEndS;
        pwr == PS_STAB && stabCnt == 12'h001;
    endsequence

    opt_read_zero_a: assert property (
        arvalid && arready && rdOpt |=> rvalid && rdata == 32'h0)
        else $error("Option register read returned data.");

    opt_unused_a: assert property (
        (optReg & ~IOP_OPT_USED) == 8'h00)
        else $error("Unused option bits were stored.");

    src1_edge_a: assert property (
        !levelSel && src1Edge ##1 !levelSel |-> s1Latch)
        else $error("Source 1 edge was not latched.");

    src2_pol_a: assert property (
        edgePol && pinSync[2] && !pinPrev[2] |=> s2Latch)
        else $error("Rising edge missed on source 2.");

    mask_gate_a: assert property (
        !globalIrqEnable |-> irqGrant[4:1] == 4'h0)
        else $error("Maskable grant with enable low.");

    no_wake_a: assert property (
        (pwr == PS_WAIT || pwr == PS_STOP) && !globalIrqEnable |=> $stable(pwr))
        else $error("Low power left with enable low.");

    wait_wake_a: assert property (
        pwr == PS_WAIT && waitWake |=> pwr == PS_RUN && wakeResume)
        else $error("Wait wake was delayed.");

    stab_start_a: assert property (
        stopWakeS |=> pwr == PS_STAB && stabCnt == IOP_STAB_LOAD && oscEnable)
        else $error("Stabilisation did not start.");

    stab_end_a: assert property (
        stabEndS |=> pwr == PS_RUN && wakeResume)
        else $error("Stabilisation end not honoured.");

    stop_as_wait_a: assert property (
        pwr == PS_RUN && stopExec && wdActive && !enabledPending |=> pwr == PS_WAIT)
        else $error("Stop entered with watchdog on.");

    skip_entry_a: assert property (
        pwr == PS_RUN && lpEnter && enabledPending |=> instrSkip && pwr == PS_RUN)
        else $error("Low power entered with request pending.");

    nmi_first_a: assert property (
        pwr == PS_RUN && nmiOk |-> irqGrant == 5'h01)
        else $error("NMI did not take priority.");
endmodule

// ---- iop_pkg.sv ----
// Purpose: Shared constants and types for the interrupt option and low-power controller.
// Assumes: 100 MHz system clock, AXI4-Lite register access with 8-bit byte addresses.
// Notes: Every offset, field position, reset value and timing count lives here.
package iop_pkg;
    // Register byte addresses.
    localparam logic [7:0] IOP_OPT_OFS = 8'hc8;
    localparam logic [7:0] IOP_MASK_OFS = 8'hcc;
    localparam logic [7:0] IOP_STAT_OFS = 8'hd0;

    // Interrupt option register fields.
    localparam int IOP_LEVEL_BIT = 6;
    localparam int IOP_POL_BIT = 5;
    localparam int IOP_ENABLE_BIT = 4;
    localparam logic [7:0] IOP_OPT_RESET = 8'h00;
    localparam logic [7:0] IOP_OPT_USED = 8'h70;

    // Peripheral mask register fields.
    localparam int IOP_MSK_TIMER = 0;
    localparam int IOP_MSK_CONV = 1;
    localparam int IOP_MSK_OSC32 = 2;
    localparam int IOP_MSK_OSCSEL = 3;
    localparam logic [7:0] IOP_MASK_RESET = 8'h00;
    localparam logic [7:0] IOP_MASK_USED = 8'h0f;

    // Status register fields.
    localparam int IOP_STAT_PWR_LSB = 0;
    localparam int IOP_STAT_PEND_LSB = 4;
    localparam int IOP_STAT_MODE_LSB = 9;

    // Core execution modes reported by the core.
    localparam logic [1:0] IOP_MODE_NORMAL = 2'h0;
    localparam logic [1:0] IOP_MODE_IRQ = 2'h1;
    localparam logic [1:0] IOP_MODE_NMI = 2'h2;

    // AXI responses.
    localparam logic [1:0] IOP_RESP_OKAY = 2'h0;
    localparam logic [1:0] IOP_RESP_SLVERR = 2'h2;

    // Oscillator stabilisation after a stop wake-up.
    localparam int IOP_CLK_PERIOD_NS = 10;
    localparam int IOP_OSC_STAB_NS = 20480;
    localparam int IOP_OSC_STAB_CYC =
        (IOP_OSC_STAB_NS + IOP_CLK_PERIOD_NS - 1) / IOP_CLK_PERIOD_NS;
    localparam logic [11:0] IOP_STAB_LOAD = 12'(IOP_OSC_STAB_CYC);

    typedef enum logic [3:0] {
        PS_RUN = 4'h1,
        PS_WAIT = 4'h2,
        PS_STOP = 4'h4,
        PS_STAB = 4'h8
    } iop_pwr_t;
endpackage

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the interrupt option and low-power controller.
// Assumes: Expected grants come from a fixed-priority integer model below.
// Notes: Stop wake is measured against the full stabilisation count.
`timescale 1ns/1ps
module tb_top import iop_pkg::*;;
    logic clk = 1'b0, rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf, ackLag = 4'h3;
    logic awready, wready, bvalid, arready, rvalid, ackValid;
    logic [1:0] bresp, rresp, coreMode = 2'h0;
    logic waitExec = 1'b0, stopExec = 1'b0, wdActive = 1'b0;
    logic [2:0] ackSrc;
    logic [4:0] irqGrant;
    logic fetchHalt, oscEnable, oscSelect, wakeResume, instrSkip;
    logic spiDone = 1'b0, timerZero = 1'b0, osc32Event = 1'b0, convDone = 1'b0;
    logic nmiPin_b = 1'b1, src1Pin_b = 1'b1, src2Pin = 1'b1;
    int nMismatch = 0, totalChecks = 0, cyc = 0, n = 0;
    logic [31:0] seed = 32'd31374, rd;
    logic [1:0] rsp;

    iop_ctrl uut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .waitExec(waitExec), .stopExec(stopExec),
        .coreMode(coreMode), .wdActive(wdActive), .ackValid(ackValid), .ackSrc(ackSrc),
        .irqGrant(irqGrant), .fetchHalt(fetchHalt), .oscEnable(oscEnable),
        .oscSelect(oscSelect), .wakeResume(wakeResume), .instrSkip(instrSkip),
        .spiDone(spiDone), .timerZero(timerZero), .osc32Event(osc32Event),
        .convDone(convDone), .nmiPin_b(nmiPin_b), .src1Pin_b(src1Pin_b), .src2Pin(src2Pin));

    iop_core_model core (.clk(clk), .rst_b(rst_b), .irqGrant(irqGrant), .ackLag(ackLag),
        .ackValid(ackValid), .ackSrc(ackSrc));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xrand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Fixed priority: the lowest numbered pending source wins.
    function automatic logic [4:0] prio(input int req);
        for (int i = 0; i < 5; i++) begin
            if (((req >> i) & 1) == 1) return 5'(1 << i);
        end
        return 5'h00;
    endfunction

    task automatic wrap_up();
        $display("Checks made %0d, mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= (xrand() << 8) | 32'(v);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (!aw && !w && bvalid === 1'b1) break;
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        rsp = bresp;
        bready <= 1'b0;
        chk(32'(rsp), 32'(IOP_RESP_OKAY), "write response");
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (!arvalid && rvalid === 1'b1) break;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic wait_grant(input int req, input int lim, input string what);
        int k;
        k = 0;
        while (irqGrant !== prio(req) && k < lim) begin
            tick(1);
            k++;
        end
        chk(32'(irqGrant), 32'(prio(req)), what);
    endtask

    task automatic core_op(input logic stp);
        @(posedge clk);
        waitExec <= !stp;
        stopExec <= stp;
        @(posedge clk);
        waitExec <= 1'b0;
        stopExec <= 1'b0;
        #1;
    endtask

    task automatic wait_wake(input int lim);
        n = 0;
        while (wakeResume !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    // The whole sequence needs well under ten thousand cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            nMismatch++;
            $display("Error at %0t: run did not finish", $time);
            wrap_up();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rdr(IOP_OPT_OFS);
        chk(rd, 32'h0, "option read");
        rdr(IOP_STAT_OFS);
        chk(rd, 32'h1, "status after reset");
        rdr(8'hf0);
        chk(32'(rsp), 32'(IOP_RESP_SLVERR), "unmapped read");
        $display("Test reset done");
        wr(IOP_OPT_OFS, 8'h8f);
        wr(IOP_MASK_OFS, 8'h01);
        @(posedge clk);
        {osc32Event, convDone, timerZero} <= 3'b111;
        tick(8);
        chk(32'(irqGrant), 32'h0, "global enable off");
        wr(IOP_OPT_OFS, 8'h10);
        for (int i = 0; i < 3; i++) begin
            wr(IOP_MASK_OFS, 8'(1 << i));
            wait_grant(i == 1 ? 16 : 8, 10, "peripheral route");
        end
        wr(IOP_MASK_OFS, 8'h00);
        wait_grant(0, 10, "all masked");
        $display("Test routing done");
        wr(IOP_OPT_OFS, 8'h50);
        wr(IOP_MASK_OFS, 8'h01);
        @(posedge clk);
        {osc32Event, convDone, spiDone} <= 3'b001;
        nmiPin_b <= 1'b0;
        wait_grant(1 | 2 | 8, 10, "nmi first");
        wait_grant(2 | 8, 10, "source 1 next");
        @(posedge clk);
        spiDone <= 1'b0;
        nmiPin_b <= 1'b1;
        wait_grant(8, 10, "source 3 last");
        @(posedge clk);
        timerZero <= 1'b0;
        src1Pin_b <= 1'b0;
        wait_grant(2, 10, "level source 1");
        tick(8);
        chk(32'(irqGrant), 32'h2, "level holds");
        @(posedge clk);
        src1Pin_b <= 1'b1;
        wait_grant(0, 10, "level released");
        wr(IOP_OPT_OFS, 8'h10);
        @(posedge clk);
        ackLag <= 4'h0;
        src1Pin_b <= 1'b0;
        tick(3);
        @(posedge clk);
        src1Pin_b <= 1'b1;
        wait_grant(2, 10, "edge source 1");
        tick(8);
        chk(32'(irqGrant), 32'h2, "edge latched");
        @(posedge clk);
        ackLag <= 4'h3;
        wait_grant(0, 10, "edge served");
        $display("Test source 1 done");
        for (int pol = 1; pol >= 0; pol--) begin
            wr(IOP_OPT_OFS, 8'h10 | 8'(pol << 5));
            @(posedge clk);
            src2Pin <= !pol;
            tick(8);
            chk(32'(irqGrant), 32'h0, "wrong edge before");
            @(posedge clk);
            src2Pin <= pol;
            wait_grant(4, 10, "source 2 edge");
            wait_grant(0, 10, "source 2 served");
            @(posedge clk);
            src2Pin <= !pol;
            tick(8);
            chk(32'(irqGrant), 32'h0, "wrong edge after");
        end
        $display("Test source 2 done");
        wr(IOP_OPT_OFS, 8'h00);
        @(posedge clk);
        nmiPin_b <= 1'b0;
        wait_grant(1, 10, "nmi with enable off");
        wait_grant(0, 10, "nmi served");
        wr(IOP_OPT_OFS, 8'h10);
        @(posedge clk);
        nmiPin_b <= 1'b1;
        ackLag <= 4'h0;
        coreMode <= IOP_MODE_IRQ;
        timerZero <= 1'b1;
        wr(IOP_MASK_OFS, 8'h01);
        tick(8);
        chk(32'(irqGrant), 32'h0, "maskable in handler");
        @(posedge clk);
        coreMode <= IOP_MODE_NMI;
        nmiPin_b <= 1'b0;
        tick(8);
        chk(32'(irqGrant), 32'h0, "nmi in nmi handler");
        @(posedge clk);
        coreMode <= IOP_MODE_IRQ;
        wait_grant(1, 10, "nmi over handler");
        @(posedge clk);
        ackLag <= 4'h3;
        wait_grant(0, 10, "handler resumes");
        @(posedge clk);
        coreMode <= IOP_MODE_NORMAL;
        nmiPin_b <= 1'b1;
        wait_grant(8, 10, "main routine");
        core_op(1'b0);
        chk({31'h0, instrSkip}, 32'h1, "skip pulse");
        chk({31'h0, fetchHalt}, 32'h0, "no halt on skip");
        $display("Test modes done");
        @(posedge clk);
        timerZero <= 1'b0;
        wr(IOP_MASK_OFS, 8'h09);
        rdr(IOP_MASK_OFS);
        chk(rd, 32'h9, "mask readback");
        for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            wdActive <= (s == 2);
            core_op(s == 1 || s == 2);
            chk({30'h0, fetchHalt, oscEnable}, s == 1 ? 32'h2 : 32'h3, "low power");
            @(posedge clk);
            if (s == 1) timerZero <= 1'b1;
            tick(20);
            chk({31'h0, fetchHalt}, 32'h1, "still halted");
            rdr(IOP_STAT_OFS);
            chk(rd, s == 1 ? 32'h84 : 32'h2, "status asleep");
            @(posedge clk);
            timerZero <= (s != 1);
            src2Pin <= (s != 1);
            wait_wake(2200);
            if (s == 1) begin
                chk(32'(n >= IOP_OSC_STAB_CYC && n <= IOP_OSC_STAB_CYC + 8), 32'h1, "stab");
            end else begin
                chk(32'(n <= 3), 32'h1, "prompt wake");
            end
            chk(32'(irqGrant), s == 1 ? 32'h4 : 32'h8, "waking grant");
            chk({30'h0, oscSelect, fetchHalt}, 32'h2, "resumed");
            @(posedge clk);
            timerZero <= 1'b0;
            src2Pin <= 1'b1;
            wait_grant(0, 10, "served after wake");
        end
        $display("Test low power done");
        @(posedge clk);
        wdActive <= 1'b0;
        wr(IOP_OPT_OFS, 8'h00);
        core_op(1'b0);
        @(posedge clk);
        nmiPin_b <= 1'b0;
        timerZero <= 1'b1;
        tick(20);
        chk({31'h0, fetchHalt}, 32'h1, "no wake enable off");
        @(posedge clk);
        nmiPin_b <= 1'b1;
        rst_b <= 1'b0;
        tick(2);
        @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        chk({31'h0, fetchHalt}, 32'h0, "reset exits");
        rdr(IOP_STAT_OFS);
        chk(rd, 32'h1, "status after reset");
        $display("Test reset exit done");
        wrap_up();
    end
endmodule
